// ===== logic/asc_pkg.sv
/*
  Constants for the step-six configuration register of the auxiliary
  converter sequencer: address, reset value, field positions, codes.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package asc_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] ASC_STEP6_CFG_IDX = 8'h96;
  localparam logic [11:0] ASC_STEP6_CFG_ADDR = 12'h258; // Index times four
  localparam logic [15:0] ASC_STEP6_CFG_RESET = 16'h0006;
  localparam logic [15:0] ASC_STEP6_CFG_WMASK = 16'he01f;
  localparam logic [7:0] ASC_STATUS_IDX = 8'h98;
  localparam logic [11:0] ASC_STATUS_ADDR = 12'h260; // Index times four
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ASC_EN_BIT = 15;
  localparam int ASC_GAIN_HI = 14;
  localparam int ASC_GAIN_LO = 13;
  localparam int ASC_NEG_BIT = 4;
  localparam int ASC_POS_HI = 3;
  localparam int ASC_POS_LO = 0;
  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [1:0] ASC_GAIN_X1 = 2'h0;
  localparam logic [1:0] ASC_GAIN_X2 = 2'h1;
  localparam logic [2:0] ASC_GAIN_ONE = 3'h1;
  localparam logic [2:0] ASC_GAIN_TWO = 3'h2;
  localparam logic [2:0] ASC_GAIN_FOUR = 3'h4;
  localparam logic [3:0] ASC_POS_TEMP = 4'h8;
  localparam logic [3:0] ASC_POS_SHORT = 4'h9;
  localparam logic [3:0] ASC_POS_DAC = 4'ha;
  localparam logic [3:0] ASC_POS_SUPPLY = 4'hb;
  // Source class one-hot: external, temp, short, dac, supply
  localparam logic [4:0] ASC_SRC_EXT = 5'h01;
  localparam logic [4:0] ASC_SRC_TEMP = 5'h02;
  localparam logic [4:0] ASC_SRC_SHORT = 5'h04;
  localparam logic [4:0] ASC_SRC_DAC = 5'h08;
  localparam logic [4:0] ASC_SRC_SUPPLY = 5'h10;
  // Negative input: 0 ground, 1 input seven, 2 automatic
  localparam logic [1:0] ASC_NEG_GND = 2'h0;
  localparam logic [1:0] ASC_NEG_IN7 = 2'h1;
  localparam logic [1:0] ASC_NEG_AUTO = 2'h2;
  localparam logic [2:0] ASC_STEP_SIX = 3'h6;
endpackage

// ===== logic/asc_step6_cfg.sv
/*
  Step-six configuration register of the auxiliary converter sequencer,
  with an APB slave and the decode that applies the step's selections.
  Assumes the sequencer presents its current step number and a start
  strobe on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - register at 96h, resets to 0006h
// - bit 15 enables step six
// - gain 00 one, 01 two, else four
// - bit 4 picks ground or input seven
// - codes 0 to 7 pick external inputs
// - 8 temperature sensor, 9 internal short
// - code 10 routes test DAC
// - codes 11 to 15 pick supply monitors
// - internal codes choose negative input automatically
module asc_step6_cfg (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [2:0] seq_step,
  input wire logic seq_start,
  output logic conv_start,
  output logic step_skip,
  output logic [2:0] conv_gain,
  output logic [4:0] conv_src,
  output logic [3:0] conv_pos,
  output logic [1:0] conv_neg
);
  import asc_pkg::*;

  // ----------------------------------------
  // Configuration register
  // ----------------------------------------
  logic [15:0] cfg_reg;
  logic [31:0] prdata_next;
  logic err_next;
  logic [7:0] conv_count_reg;
  logic [7:0] skip_count_reg;
  logic access;
  logic wr_cfg;
  logic [2:0] gain_next;
  logic [4:0] src_next;
  logic [1:0] neg_next;
  logic [3:0] pos_sel;

  assign access = psel && penable && !pready;
  assign wr_cfg = psel && penable && pready && pwrite && paddr == ASC_STEP6_CFG_ADDR;
  assign pos_sel = cfg_reg[ASC_POS_HI:ASC_POS_LO];

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg <= ASC_STEP6_CFG_RESET;
    end else if (wr_cfg) begin
      cfg_reg <= pwdata[15:0] & ASC_STEP6_CFG_WMASK;
    end
  end

  // ----------------------------------------
  // APB answer, one wait state
  // ----------------------------------------
  always_comb begin
    prdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == ASC_STEP6_CFG_ADDR) begin
      prdata_next = {16'h0000, cfg_reg};
    end else if (paddr == ASC_STATUS_ADDR) begin
      prdata_next = {16'h0000, skip_count_reg, conv_count_reg};
      err_next = pwrite;
    end else begin
      err_next = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= access;
      pslverr <= access && err_next;
      if (access && !pwrite) begin
        prdata <= prdata_next;
      end
    end
  end

  // ----------------------------------------
  // Selection decode
  // ----------------------------------------
  always_comb begin
    case (cfg_reg[ASC_GAIN_HI:ASC_GAIN_LO])
      ASC_GAIN_X1: gain_next = ASC_GAIN_ONE;
      ASC_GAIN_X2: gain_next = ASC_GAIN_TWO;
      default: gain_next = ASC_GAIN_FOUR;
    endcase
    if (pos_sel < ASC_POS_TEMP) begin
      src_next = ASC_SRC_EXT;
    end else if (pos_sel == ASC_POS_TEMP) begin
      src_next = ASC_SRC_TEMP;
    end else if (pos_sel == ASC_POS_SHORT) begin
      src_next = ASC_SRC_SHORT;
    end else if (pos_sel == ASC_POS_DAC) begin
      src_next = ASC_SRC_DAC;
    end else begin
      src_next = ASC_SRC_SUPPLY;
    end
    if (pos_sel >= ASC_POS_TEMP) begin
      neg_next = ASC_NEG_AUTO;
    end else if (cfg_reg[ASC_NEG_BIT]) begin
      neg_next = ASC_NEG_IN7;
    end else begin
      neg_next = ASC_NEG_GND;
    end
  end

  // ----------------------------------------
  // Step application
  // ----------------------------------------
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_start <= 1'b0;
      step_skip <= 1'b0;
      conv_gain <= ASC_GAIN_ONE;
      conv_src <= ASC_SRC_EXT;
      conv_pos <= 4'h0;
      conv_neg <= ASC_NEG_GND;
    end else begin
      conv_start <= seq_start && seq_step == ASC_STEP_SIX && cfg_reg[ASC_EN_BIT];
      step_skip <= seq_start && seq_step == ASC_STEP_SIX && !cfg_reg[ASC_EN_BIT];
      if (seq_start && seq_step == ASC_STEP_SIX && cfg_reg[ASC_EN_BIT]) begin
        conv_gain <= gain_next;
        conv_src <= src_next;
        conv_pos <= pos_sel;
        conv_neg <= neg_next;
      end
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      conv_count_reg <= 8'h00;
      skip_count_reg <= 8'h00;
    end else begin
      if (conv_start) begin
        conv_count_reg <= conv_count_reg + 8'h01;
      end
      if (step_skip) begin
        skip_count_reg <= skip_count_reg + 8'h01;
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_cfg_write;
    psel && penable && pready && pwrite && paddr == ASC_STEP6_CFG_ADDR;
  endsequence

  sequence s_cfg_read;
    psel && penable && !pready && !pwrite && paddr == ASC_STEP6_CFG_ADDR;
  endsequence

  sequence s_bus_access;
    psel && penable && !pready;
  endsequence

  sequence s_bad_access;
    s_bus_access ##0 paddr != ASC_STEP6_CFG_ADDR && paddr != ASC_STATUS_ADDR;
  endsequence

  sequence s_bus_answer;
    pready ##1 !pready;
  endsequence

  sequence s_step6_enabled;
    seq_start && seq_step == ASC_STEP_SIX && cfg_reg[ASC_EN_BIT];
  endsequence

  sequence s_step6_disabled;
    seq_start && seq_step == ASC_STEP_SIX && !cfg_reg[ASC_EN_BIT];
  endsequence

  sequence s_other_step;
    seq_start && seq_step != ASC_STEP_SIX;
  endsequence

  // ----------------------------------------
  // Bus checks
  // ----------------------------------------
  reset_value_a: assert property (@(posedge mclk)
    $rose(arst_n) |-> cfg_reg == ASC_STEP6_CFG_RESET)
    else $error("config not at reset value");

  bus_pulse_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_bus_access |=> s_bus_answer)
    else $error("bus answer not one pulse");

  cfg_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_read |=> prdata[15:0] == $past(cfg_reg) && !pslverr)
    else $error("config read wrong");

  bad_addr_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_bad_access |=> pslverr && ($past(pwrite) || prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  status_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_bus_access ##0 pwrite && paddr == ASC_STATUS_ADDR |=> pslverr)
    else $error("status write not refused");

  enable_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_write |=> cfg_reg[ASC_EN_BIT] == $past(pwdata[15]))
    else $error("enable bit not written");

  cfg_hold_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !wr_cfg |=> $stable(cfg_reg))
    else $error("config changed without write");

  gain_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_write |=> cfg_reg[14:13] == $past(pwdata[14:13]))
    else $error("gain field not written");

  neg_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_write |=> cfg_reg[4] == $past(pwdata[4]))
    else $error("negative select not written");

  pos_write_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_write |=> cfg_reg[3:0] == $past(pwdata[3:0]))
    else $error("positive select not written");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_write |=> cfg_reg[12:5] == 8'h00)
    else $error("reserved bits not zero");

  reserved_read_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_cfg_read |=> prdata[31:16] == 16'h0000 && prdata[12:5] == 8'h00)
    else $error("reserved bits read nonzero");

  // ----------------------------------------
  // Step checks
  // ----------------------------------------
  gain_apply_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled |=> conv_gain == (($past(cfg_reg[14:13]) == 2'h0) ? 3'h1 :
      ($past(cfg_reg[14:13]) == 2'h1) ? 3'h2 : 3'h4))
    else $error("wrong gain applied");

  gain_four_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 cfg_reg[14] |=> conv_gain == 3'h4)
    else $error("upper gain codes not four");

  neg_pick_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 !cfg_reg[3] |=> conv_neg == {1'b0, $past(cfg_reg[4])})
    else $error("wrong negative input");

  ext_src_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 !cfg_reg[3] |=> conv_src == 5'h01 && conv_pos == $past(cfg_reg[3:0]))
    else $error("external input not applied");

  temp_short_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 cfg_reg[3:1] == 3'h4 |=> conv_src == ($past(cfg_reg[0]) ? 5'h04 : 5'h02))
    else $error("internal source wrong");

  dac_src_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 cfg_reg[3:0] == 4'ha |=> conv_src == 5'h08)
    else $error("test source wrong");

  supply_src_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 cfg_reg[3:0] > 4'ha |=> conv_src == 5'h10)
    else $error("supply source wrong");

  auto_neg_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled ##0 cfg_reg[3] |=> conv_neg == 2'h2)
    else $error("negative not automatic");

  start_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_enabled |=> conv_start && !step_skip)
    else $error("enabled step not applied");

  skip_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_step6_disabled |=> step_skip && !conv_start)
    else $error("disabled step not skipped");

  other_step_a: assert property (@(posedge mclk) disable iff (!arst_n)
    s_other_step |=> !conv_start && !step_skip)
    else $error("other step acted on");

  hold_sel_a: assert property (@(posedge mclk) disable iff (!arst_n)
    !(seq_start && seq_step == ASC_STEP_SIX && cfg_reg[ASC_EN_BIT]) |=>
      $stable(conv_gain) && $stable(conv_src) && $stable(conv_pos) && $stable(conv_neg))
    else $error("selections changed without step");

  count_conv_a: assert property (@(posedge mclk) disable iff (!arst_n)
    conv_start |=> conv_count_reg == $past(conv_count_reg) + 8'h01)
    else $error("conversion count not advanced");
endmodule
`default_nettype wire

// ===== verification/test_adc_sequence_step6_config.sv
/*
  Self-checking bench for the step-six configuration register.
  Assumes asc_pkg and asc_step6_cfg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module test_adc_sequence_step6_config;
  import asc_pkg::*;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_start, step_skip;
  logic [2:0] seq_step = 3'h0;
  logic seq_start = 1'b0;
  logic [2:0] conv_gain;
  logic [4:0] conv_src;
  logic [3:0] conv_pos;
  logic [1:0] conv_neg;
  int n_fail = 0;
  int checked = 0;
  logic [31:0] rd, d;
  logic [2:0] other;
  int n_conv = 0;
  int n_skip = 0;
  logic er;
  asc_step6_cfg uut (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .seq_step(seq_step), .seq_start(seq_start),
    .conv_start(conv_start), .step_skip(step_skip), .conv_gain(conv_gain),
    .conv_src(conv_src), .conv_pos(conv_pos), .conv_neg(conv_neg));
  always #50 mclk = ~mclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [39:0] g, input logic [39:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic step(input logic [2:0] s);
    @(posedge mclk);
    seq_step <= s;
    seq_start <= 1'b1;
    @(posedge mclk);
    seq_start <= 1'b0;
    #1;
  endtask
  function automatic logic [13:0] expo(input logic [15:0] c);
    logic [2:0] g;
    logic [4:0] s;
    g = (c[14:13] == 2'h0) ? 3'h1 : (c[14:13] == 2'h1) ? 3'h2 : 3'h4;
    s = !c[3] ? 5'h01 : (c[3:0] == 4'h8) ? 5'h02 : (c[3:0] == 4'h9) ? 5'h04 :
        (c[3:0] == 4'ha) ? 5'h08 : 5'h10;
    return {g, s, c[3:0], (c[3] ? 2'h2 : {1'b0, c[4]})};
  endfunction
  task automatic close_out;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (5000) @(posedge mclk);
    n_fail++;
    close_out();
  end
  initial begin
    void'($urandom(32'he3f6c47b));
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, ASC_STEP6_CFG_ADDR, 32'h0);
    chk({er, rd}, 33'h0_0000_0006);
    step(3'h6);
    chk({conv_start, step_skip}, 2'b01);
    n_skip++;
    for (int i = 0; i < 32; i++) begin
      d = $urandom;
      d[15] = i[0] ^ i[4];
      d[3:0] = i[3:0];
      apb(1'b1, ASC_STEP6_CFG_ADDR, d);
      chk(er, 1'b0);
      apb(1'b0, ASC_STEP6_CFG_ADDR, 32'h0);
      chk({er, rd}, {1'b0, d & 32'h0000_e01f});
      other = 3'($urandom_range(0, 6));
      if (other == 3'h6) other = 3'h7;
      step(other);
      chk({conv_start, step_skip}, 2'b00);
      step(3'h6);
      chk({conv_start, step_skip}, {d[15], !d[15]});
      n_conv += d[15];
      n_skip += !d[15];
      if (d[15]) chk({conv_gain, conv_src, conv_pos, conv_neg}, expo(d[15:0]));
    end
    apb(1'b1, ASC_STATUS_ADDR, 32'hffff_ffff);
    chk(er, 1'b1);
    apb(1'b0, ASC_STATUS_ADDR, 32'h0);
    chk({er, rd}, {1'b0, 16'h0000, 8'(n_skip), 8'(n_conv)});
    apb(1'b0, 12'h100, 32'h0);
    chk({er, rd}, 33'h1_0000_0000);
    @(posedge mclk);
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, ASC_STEP6_CFG_ADDR, 32'h0);
    chk({er, rd}, 33'h0_0000_0006);
    apb(1'b0, ASC_STATUS_ADDR, 32'h0);
    chk({er, rd}, 33'h0_0000_0000);
    close_out();
  end
endmodule
`default_nettype wire
